// >>> rtl/dvm_pkg.sv
// Constants for the dual-view shared memory map.
// Assumes one system clock; used by dvm_shared_map and dvm_shared_map_bench.
package dvm_pkg;
  // ==========================================================
  // Address views
  localparam int HOST_AW = 13;
  localparam int TASK_AW = 14;
  localparam int BUF_WORDS = 3072;
  localparam int COMMON_BYTES = 8192;
  localparam int XCH_WORDS = BUF_WORDS + COMMON_BYTES / 2;
  localparam logic [HOST_AW-1:0] HOST_BUF_LAST = 13'h0bff;
  localparam logic [HOST_AW-1:0] HOST_COMMON_FIRST = 13'h0c00;
  localparam logic [HOST_AW-1:0] HOST_LAST = 13'h1bff;
  localparam logic [TASK_AW-1:0] TASK_BUF_LAST = 14'h17ff;
  localparam logic [TASK_AW-1:0] TASK_COMMON_FIRST = 14'h1800;
  localparam logic [TASK_AW-1:0] TASK_LAST = 14'h37ff;
  // ==========================================================
  // Byte lanes of a 16-bit word
  localparam logic [1:0] BE_LO = 2'h1;
  localparam logic [1:0] BE_HI = 2'h2;
  localparam logic [1:0] BE_ALL = 2'h3;
  // ==========================================================
  // Program area
  localparam int PROG_AW = 16;
  localparam logic [PROG_AW:0] PROG_BYTES = 17'h10000;
  localparam logic [PROG_AW:0] PART_UNIT = 17'h04000;
  localparam int PART_SEL_W = 2;
  localparam int NUM_TASKS = 2;
  // ==========================================================
  typedef enum logic [1:0] {S_LOAD, S_IDLE, S_MEM, S_DONE} dvm_state_t;
endpackage

// >>> rtl/dvm_mem.sv
// Single-port RAM with byte enables and registered read data.
// Assumes en is already qualified by the clock enable.
`timescale 1ns/1ps
`default_nettype none
module dvm_mem #(
  parameter int DW = 16,
  parameter int DEPTH = 7168,
  parameter int AW = 13
) (
  input wire logic clk_sys,
  input wire logic en,
  input wire logic we,
  input wire logic [DW/8-1:0] be,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  typedef struct packed {
    logic [DW-1:0] rdata;
  } dvm_mem_regs_t;

  dvm_mem_regs_t q, d;
  logic [DW-1:0] ram_word;

  // ==========================================================
  // Per-lane storage, each array written by one process only
  for (genvar i = 0; i < DW / 8; i++) begin : g_lane
    // Contents are volatile and never initialised
    logic [7:0] lane_ram [DEPTH];
    always_ff @(posedge clk_sys) begin
      if (en && we && be[i]) begin
        lane_ram[addr] <= wdata[i*8 +: 8];
      end
    end
    assign ram_word[i*8 +: 8] = lane_ram[addr];
  end

  always_comb begin
    d = q;
    if (en && !we) begin
      d.rdata = ram_word;
    end
  end

  always_ff @(posedge clk_sys) begin
    q <= d;
  end

  assign rdata = q.rdata;
endmodule
`default_nettype wire

// >>> rtl/dvm_shared_map.sv
// Shared exchange memory seen as words by the host and as bytes by tasks,
// plus the program area loaded from nonvolatile store after reset.
// Assumes all inputs come from logic on clk_sys; requesters hold req until ack.
`timescale 1ns/1ps
`default_nettype none
module dvm_shared_map (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic host_req,
  input wire logic host_we,
  input wire logic [dvm_pkg::HOST_AW-1:0] host_addr,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  output logic host_ack,
  output logic host_err,
  input wire logic task_req,
  input wire logic task_we,
  input wire logic [dvm_pkg::TASK_AW-1:0] task_addr,
  input wire logic [7:0] task_wdata,
  output logic [7:0] task_rdata,
  output logic task_ack,
  output logic task_err,
  input wire logic prog_req,
  input wire logic [dvm_pkg::PROG_AW-1:0] prog_addr,
  output logic [7:0] prog_rdata,
  input wire logic [dvm_pkg::PART_SEL_W-1:0] part_sel,
  input wire logic [dvm_pkg::NUM_TASKS-1:0] mt_enable,
  output logic nvm_rd,
  output logic [dvm_pkg::PROG_AW-1:0] nvm_addr,
  input wire logic nvm_valid,
  input wire logic [7:0] nvm_rdata,
  input wire logic nvm_update,
  output logic multitask_run_start_flag,
  output logic exec_enable
);
  import dvm_pkg::*;

  typedef struct packed {
    dvm_state_t st;
    logic host_sel;
    logic bad;
    logic lane;
    logic [15:0] host_rdata;
    logic host_ack;
    logic host_err;
    logic [7:0] task_rdata;
    logic task_ack;
    logic task_err;
    logic [PROG_AW:0] ld_addr;
    logic ld_wait;
    logic nvm_rd;
    logic run_flag;
    logic exec_en;
    logic loaded;
  } dvm_regs_t;

  dvm_regs_t q, d;
  logic x_en, x_we;
  logic [1:0] x_be;
  logic [HOST_AW-1:0] x_addr;
  logic [15:0] x_wdata, x_rdata;
  logic p_en, p_we;
  logic [PROG_AW-1:0] p_addr;
  logic [PROG_AW:0] part_end;
  logic ld_skip;

  // ==========================================================
  // Program partition and load skip
  assign part_end = (PROG_AW+1)'((part_sel + 3'h1) * PART_UNIT);
  assign ld_skip = (q.ld_addr < part_end) ? mt_enable[0] : mt_enable[1];

  // ==========================================================
  // Next state
  always_comb begin
    d = q;
    d.host_ack = 1'b0;
    d.task_ack = 1'b0;
    d.nvm_rd = 1'b0;
    x_en = 1'b0;
    x_we = 1'b0;
    x_be = BE_ALL;
    x_addr = host_addr;
    x_wdata = host_wdata;
    p_en = 1'b0;
    p_we = 1'b0;
    p_addr = prog_addr;
    d.run_flag = q.loaded && !nvm_update;
    d.exec_en = q.loaded && !nvm_update;
    case (q.st)
      S_LOAD: begin
        p_addr = q.ld_addr[PROG_AW-1:0];
        if (q.ld_addr == PROG_BYTES) begin
          d.loaded = 1'b1;
          d.st = S_IDLE;
        end else if (ld_skip) begin
          d.ld_addr = q.ld_addr + 17'h1;
        end else if (!q.ld_wait) begin
          d.nvm_rd = 1'b1;
          d.ld_wait = 1'b1;
        end else if (nvm_valid) begin
          p_en = 1'b1;
          p_we = 1'b1;
          d.ld_addr = q.ld_addr + 17'h1;
          d.ld_wait = 1'b0;
        end
      end
      S_IDLE: begin
        p_en = prog_req && q.exec_en;
        if (nvm_update) begin
          d.st = S_IDLE;
        end else if (host_req) begin
          d.host_sel = 1'b1;
          d.bad = host_addr > HOST_LAST;
          x_en = !d.bad;
          x_we = host_we;
          d.st = S_MEM;
        end else if (task_req) begin
          d.host_sel = 1'b0;
          d.bad = task_addr > TASK_LAST;
          d.lane = task_addr[0];
          x_en = !d.bad;
          x_we = task_we;
          x_addr = task_addr[TASK_AW-1:1];
          x_be = task_addr[0] ? BE_HI : BE_LO;
          x_wdata = {task_wdata, task_wdata};
          d.st = S_MEM;
        end
      end
      S_MEM: begin
        if (q.host_sel) begin
          d.host_rdata = q.bad ? 16'h0 : x_rdata;
          d.host_err = q.bad;
          d.host_ack = 1'b1;
        end else begin
          d.task_rdata = q.bad ? 8'h0 : (q.lane ? x_rdata[15:8] : x_rdata[7:0]);
          d.task_err = q.bad;
          d.task_ack = 1'b1;
        end
        d.st = S_DONE;
      end
      S_DONE: begin
        d.st = S_IDLE;
      end
      default: begin
        d.st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '0;
      q.st <= S_LOAD;
    end else if (ce) begin
      q <= d;
    end
  end

  // ==========================================================
  // Storage: buffer words then common memory in one array
  dvm_mem #(
    .DW(16),
    .DEPTH(XCH_WORDS),
    .AW(HOST_AW)
  ) u_xch (
    .clk_sys(clk_sys),
    .en(x_en && ce),
    .we(x_we),
    .be(x_be),
    .addr(x_addr),
    .wdata(x_wdata),
    .rdata(x_rdata)
  );

  dvm_mem #(
    .DW(8),
    .DEPTH(int'(PROG_BYTES)),
    .AW(PROG_AW)
  ) u_prog (
    .clk_sys(clk_sys),
    .en(p_en && ce),
    .we(p_we),
    .be(1'b1),
    .addr(p_addr),
    .wdata(nvm_rdata),
    .rdata(prog_rdata)
  );

  assign host_rdata = q.host_rdata;
  assign host_ack = q.host_ack;
  assign host_err = q.host_err;
  assign task_rdata = q.task_rdata;
  assign task_ack = q.task_ack;
  assign task_err = q.task_err;
  assign nvm_rd = q.nvm_rd;
  assign nvm_addr = q.ld_addr[PROG_AW-1:0];
  assign multitask_run_start_flag = q.run_flag;
  assign exec_enable = q.exec_en;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst || !ce);

  a_host_range_err: assert property ((q.st == S_IDLE && !nvm_update && host_req && host_addr > HOST_LAST)
    |-> ##2 (host_ack && host_err)) else $error("host out of range not flagged");
  a_host_ack_pulse: assert property (host_ack |=> !host_ack) else $error("host ack longer than one cycle");
  a_task_latency: assert property ((q.st == S_IDLE && !nvm_update && !host_req && task_req)
    |-> ##2 (task_ack && (task_err == (($past(task_addr, 2)) > TASK_LAST)))) else $error("task answer wrong");
  a_suspend_idle: assert property (nvm_update |-> !x_en) else $error("memory access during update");
  a_flag_drop: assert property (nvm_update |=> (!multitask_run_start_flag && !exec_enable))
    else $error("activity not suspended");
  a_skip_nowrite: assert property ((q.st == S_LOAD && ld_skip) |-> !p_we) else $error("skipped area loaded");
  a_load_after_rst: assert property ($past(rst) |-> (q.st == S_LOAD && !multitask_run_start_flag))
    else $error("no program copy after reset");
  a_task_lane: assert property ((x_en && q.st == S_IDLE && !host_req)
    |-> (x_be == (task_addr[0] ? BE_HI : BE_LO))) else $error("byte lane wrong");
  a_part_size: assert property (part_end >= PART_UNIT && part_end <= PROG_BYTES && part_end[13:0] == 14'h0)
    else $error("partition size illegal");
endmodule
`default_nettype wire

// >>> dv/dvm_nvm_model.sv
// Nonvolatile store model feeding the program load.
// Assumes nvm_rd pulses one cycle and nvm_addr holds until the byte is done.
`timescale 1ns/1ps
`default_nettype none
module dvm_nvm_model (
  input wire logic clk_sys,
  input wire logic nvm_rd,
  input wire logic [15:0] nvm_addr,
  output logic nvm_valid,
  output logic [7:0] nvm_rdata
);
  logic [2:0] wait_q = 3'h0;
  initial nvm_valid = 1'b0;
  initial nvm_rdata = 8'h00;
  // Prompt answer mostly, slow once per 1k bytes; data toggles when not valid
  always @(posedge clk_sys) begin
    nvm_valid <= 1'b0;
    nvm_rdata <= ~nvm_rdata;
    if (wait_q != 3'h0)
      wait_q <= wait_q - 3'h1;
    if ((nvm_rd && nvm_addr[9:0] != 10'h0) || wait_q == 3'h1) begin
      nvm_valid <= 1'b1;
      nvm_rdata <= nvm_addr[7:0] ^ nvm_addr[15:8] ^ 8'h5a;
    end else if (nvm_rd)
      wait_q <= 3'h4;
  end
endmodule
`default_nettype wire

// >>> dv/dvm_shared_map_bench.sv
// Self-checking bench for dvm_shared_map.
// Assumes dvm_nvm_model answers loads; task 2 area is the only one loaded.
`timescale 1ns/1ps
`default_nettype none
module dvm_shared_map_bench;
  import dvm_pkg::*;
  logic clk_sys, rst, ce, host_req, host_we, host_ack, host_err, task_req, task_we, task_ack, task_err;
  logic [1:0] part_sel, mt_enable;
  logic prog_req, nvm_rd, nvm_valid, nvm_update, run_flag, exec_en, er;
  logic [HOST_AW-1:0] host_addr;
  logic [TASK_AW-1:0] task_addr;
  logic [15:0] host_wdata, host_rdata, prog_addr, nvm_addr, rd;
  logic [7:0] task_wdata, task_rdata, prog_rdata, nvm_rdata;
  int fails = 0, n_checks = 0, lat = 0, nrd = 0, nlow = 0;

  dvm_shared_map DUT (.clk_sys(clk_sys), .rst(rst), .ce(ce), .host_req(host_req), .host_we(host_we),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata), .host_ack(host_ack),
    .host_err(host_err), .task_req(task_req), .task_we(task_we), .task_addr(task_addr),
    .task_wdata(task_wdata), .task_rdata(task_rdata), .task_ack(task_ack), .task_err(task_err),
    .prog_req(prog_req), .prog_addr(prog_addr), .prog_rdata(prog_rdata), .part_sel(part_sel),
    .mt_enable(mt_enable), .nvm_rd(nvm_rd), .nvm_addr(nvm_addr), .nvm_valid(nvm_valid),
    .nvm_rdata(nvm_rdata), .nvm_update(nvm_update), .multitask_run_start_flag(run_flag),
    .exec_enable(exec_en));
  dvm_nvm_model NVM (.clk_sys(clk_sys), .nvm_rd(nvm_rd), .nvm_addr(nvm_addr), .nvm_valid(nvm_valid),
    .nvm_rdata(nvm_rdata));

  // ==========================================================
  // Clock, watchdog, load monitor
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    fails++;
    close_out();
  end
  always @(posedge clk_sys) begin
    if (nvm_rd === 1'b1) begin
      nrd++;
      if (nvm_addr < 16'hc000)
        nlow++;
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One access on the host (h=1) or task port; holds the request until ack
  task automatic acc(input bit h, input logic we, input logic [13:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    host_we <= we;
    task_we <= we;
    host_addr <= a[12:0];
    task_addr <= a;
    host_wdata <= d;
    task_wdata <= d[7:0];
    host_req <= h;
    task_req <= !h;
    lat = 0;
    do begin
      @(posedge clk_sys);
      #1;
      lat++;
    end while ((h ? host_ack : task_ack) !== 1'b1 && lat < 40);
    rd = h ? host_rdata : {8'h00, task_rdata};
    er = h ? host_err : task_err;
    chk("ack", 16'h1, 16'(h ? host_ack : task_ack));
    @(posedge clk_sys);
    host_req <= 1'b0;
    task_req <= 1'b0;
  endtask
  task automatic look(input bit h, input logic [13:0] a, input logic [15:0] exp);
    acc(h, 1'b0, a, 16'h0);
    chk($sformatf("read %0d %h", h, a), exp, rd);
    chk("no err", 16'h0, 16'(er));
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_buffer;
    acc(1, 1, 14'h0000, 16'hbeef);
    chk("latency", 16'h2, 16'(lat));
    acc(1, 1, 14'h0bff, 16'h1234);
    look(0, 14'h0000, 16'h00ef);
    look(0, 14'h0001, 16'h00be);
    look(0, 14'h17fe, 16'h0034);
    acc(0, 1, 14'h17ff, 16'h00a5);
    look(1, 14'h0bff, 16'ha534);
    acc(1, 0, 14'h1c00, 16'h0);
    chk("host range err", 16'h1, 16'(er));
    chk("host range data", 16'h0, rd);
  endtask
  task automatic t_common;
    acc(0, 1, 14'h1800, 16'h0011);
    acc(0, 1, 14'h1801, 16'h0022);
    acc(0, 1, 14'h37fe, 16'h0088);
    acc(0, 1, 14'h37ff, 16'h0099);
    look(1, 14'h0c00, 16'h2211);
    look(1, 14'h1bff, 16'h9988);
    acc(1, 1, 14'h0c01, 16'h7766);
    look(0, 14'h1803, 16'h0077);
    acc(0, 0, 14'h3800, 16'h0);
    chk("task range err", 16'h1, 16'(er));
    chk("task range data", 16'h0, rd);
  endtask
  task automatic t_suspend;
    @(posedge clk_sys);
    nvm_update <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("flags in update", 16'h0, 16'({run_flag, exec_en}));
    fork
      acc(1, 1, 14'h0005, 16'h4321);
      begin
        repeat (12) @(posedge clk_sys);
        nvm_update <= 1'b0;
      end
    join
    chk("held off", 16'h1, 16'(lat > 12));
    look(0, 14'h000a, 16'h0021);
  endtask
  // Clock enable low for five edges stretches the answer by five edges
  task automatic t_freeze;
    fork
      acc(1, 0, 14'h0005, 16'h0);
      begin
        @(posedge clk_sys);
        ce <= 1'b0;
        repeat (5) @(posedge clk_sys);
        ce <= 1'b1;
      end
    join
    chk("frozen latency", 16'h7, 16'(lat));
    chk("frozen read", 16'h4321, rd);
  endtask
  task automatic t_prog;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      prog_req <= 1'b1;
      prog_addr <= i ? 16'hffff : 16'hc000;
      @(posedge clk_sys);
      prog_req <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk("prog byte", 16'(prog_addr[7:0] ^ prog_addr[15:8] ^ 8'h5a), 16'(prog_rdata));
    end
  endtask

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    part_sel = 2'h2;
    mt_enable = 2'h1;
    host_req = 1'b0;
    host_we = 1'b0;
    host_addr = '0;
    host_wdata = 16'h0;
    task_req = 1'b0;
    task_we = 1'b0;
    task_addr = '0;
    task_wdata = 8'h00;
    prog_req = 1'b0;
    prog_addr = 16'h0;
    nvm_update = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk("flags in load", 16'h0, 16'({run_flag, exec_en}));
    while (run_flag !== 1'b1) begin
      @(posedge clk_sys);
      #1;
    end
    chk("loaded bytes", 16'h4000, 16'(nrd));
    chk("skipped area", 16'h0, 16'(nlow));
    t_prog();
    t_buffer();
    t_common();
    t_suspend();
    t_freeze();
    close_out();
  end
endmodule
`default_nettype wire
